// file: verilog/ebtp_timer.sv
// Timer/counter with an 8-bit prescaler shared with the watchdog.
// Assumes the CPU presents one-cycle accesses on Q4, a free-running
// watchdog tick source, and an external count pin from outside the clock.
//
// Function
// - Clock-source bit clear: timer counts instruction cycles.
// - A timer write blocks counting for the next two instruction cycles.
// - Clock-source bit set: timer counts edges of the external input.
// - Edge bit clear counts rising edges, set counts falling edges.
// - Prescaler serves timer when assign bit clear, watchdog when set.
// - Three ratio bits select division by two up to 256 for the timer.
// - Prescaler is an 8-bit counter hidden from software.
// - With timer assignment, every timer write clears the prescaler.
// - With watchdog assignment, watchdog clear also clears the prescaler.
// - Any reset clears the prescaler.
// - Prescaler output or raw input is sampled on Q2 and Q4.
// - Timer step follows an input edge by three to seven periods.
// - Counter mode forces the shared pin to input.
// - Timer is 8-bit read/write at 01h, kept over non-power resets.
// - Option register resets to all ones on every reset.
// - Prescaler divides like a ripple counter with symmetrical output.
`timescale 1ns/1ps
`default_nettype none

module ebtp_timer
(
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic                   otherReset,
  input  wire ebtp_pkg::ebtp_cpu_req_t cpuReq,
  output var  logic [7:0]             fileRdata,
  input  wire logic                   extCountInput,
  input  wire logic                   watchdogTick,
  output var  logic                   watchdogPostTick,
  output var  logic                   instrTick,
  output var  ebtp_pkg::ebtp_pin_ctl_t pinCtl
);
  import ebtp_pkg::*;

  logic [1:0]   phase_reg;
  logic         q2;
  logic         q4;
  ebtp_option_t option_reg;
  logic [5:0]   pinDirection_reg;
  logic [7:0]   timer_reg;
  logic [7:0]   presc_reg;
  logic [7:0]   presc_next;
  logic [1:0]   inhibit_reg;
  logic [2:0]   sync_reg;
  logic         extHeld_reg;
  logic         extNow;
  logic         srcLevel;
  logic         srcHeld;
  logic         extEdge;
  logic         sampled_reg;
  logic         incReq_reg;
  logic         sampleSrc;
  logic         timerWr;
  logic         timerInc;
  logic         prescEvt;
  logic [7:0]   wdtMask;
  logic         cs;
  logic         prescaler_assign;
  logic [2:0]   ratio;

  assign cs      = option_reg.clockSourceSelect;
  assign prescaler_assign     = option_reg.prescalerAssign;
  assign ratio   = option_reg.prescaleRatioSel;
  assign q2      = (phase_reg == PHASE_Q2);
  assign q4      = (phase_reg == PHASE_Q4);
  assign timerWr = cpuReq.fileWe && (cpuReq.fileAddr == TIMER_ADDR);

  // Instruction phase divider, Q1 to Q4
  always_ff @(posedge mclk)
  begin
    if (rst)
      phase_reg <= PHASE_Q1;
    else
      phase_reg <= phase_reg + 2'h1;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      instrTick <= 1'b0;
    else
      instrTick <= q4;
  end

  // Option and direction registers, write only
  always_ff @(posedge mclk)
  begin
    if (rst || otherReset)
      option_reg <= OPTION_RESET;
    else if (cpuReq.optionWe)
      option_reg <= cpuReq.fileWdata;
  end

  always_ff @(posedge mclk)
  begin
    if (rst || otherReset)
      pinDirection_reg <= DIR_RESET;
    else if (cpuReq.dirWe)
      pinDirection_reg <= cpuReq.fileWdata[5:0];
  end

  // External input: three stages, a change counts once two and three agree
  always_ff @(posedge mclk)
  begin
    if (rst)
      sync_reg <= 3'h0;
    else
      sync_reg <= {sync_reg[1:0], extCountInput};
  end

  assign extNow = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : extHeld_reg;

  always_ff @(posedge mclk)
  begin
    if (rst)
      extHeld_reg <= 1'b0;
    else
      extHeld_reg <= extNow;
  end

  // Edge select folds the falling edge into a rising one
  assign srcLevel = extNow ^ option_reg.sourceEdgeSelect;
  assign srcHeld  = extHeld_reg ^ option_reg.sourceEdgeSelect;
  assign extEdge  = srcLevel && !srcHeld;

  // Prescaler input: timer source or watchdog tick
  always_comb
  begin
    if (prescaler_assign)
      prescEvt = watchdogTick;
    else if (cs)
      prescEvt = extEdge;
    else
      prescEvt = q4;
  end

  // Counting every source event matches a ripple chain's final state
  assign presc_next = presc_reg + 8'h01;

  always_ff @(posedge mclk)
  begin
    if (rst || otherReset)
      presc_reg <= PRESC_RESET;
    else if (timerWr && !prescaler_assign)
      presc_reg <= PRESC_RESET;
    else if (cpuReq.watchdogClearOp && prescaler_assign)
      presc_reg <= PRESC_RESET;
    else if (prescEvt)
      presc_reg <= presc_next;
  end

  // Prescaler bit n toggles every 2^n events, a 1:2^(n+1) square wave
  assign sampleSrc = prescaler_assign ? srcLevel : presc_reg[ratio];

  // Sampling on Q2 and Q4 turns a rising level into one step request
  always_ff @(posedge mclk)
  begin
    if (rst)
      sampled_reg <= 1'b0;
    else if (q2 || q4)
      sampled_reg <= sampleSrc;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      incReq_reg <= 1'b0;
    else
      incReq_reg <= (q2 || q4) && sampleSrc && !sampled_reg;
  end

  assign timerInc = (!cs && prescaler_assign) ? q4 : (incReq_reg && (cs || !prescaler_assign));

  // Write inhibit counted in instruction cycles
  always_ff @(posedge mclk)
  begin
    if (rst || otherReset)
      inhibit_reg <= 2'h0;
    else if (timerWr)
      inhibit_reg <= INHIBIT_CYC;
    else if (q4 && inhibit_reg != 2'h0)
      inhibit_reg <= inhibit_reg - 2'h1;
  end

  // Timer count register; other resets leave it untouched
  always_ff @(posedge mclk)
  begin
    if (rst)
      timer_reg <= TIMER_PORRST;
    else if (timerWr)
      timer_reg <= cpuReq.fileWdata;
    else if (timerInc && inhibit_reg == 2'h0 && !otherReset)
      timer_reg <= timer_reg + 8'h01;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      fileRdata <= READ_ZERO;
    else if (cpuReq.fileAddr == TIMER_ADDR)
      fileRdata <= timer_reg;
    else
      fileRdata <= READ_ZERO;
  end

  // Watchdog postscaler carry: 1:1 up to 1:128
  assign wdtMask = 8'((9'h001 << ratio) - 9'h001);

  always_ff @(posedge mclk)
  begin
    if (rst)
      watchdogPostTick <= 1'b0;
    else
      watchdogPostTick <= prescaler_assign && watchdogTick &&
                          ((presc_reg & wdtMask) == wdtMask);
  end

  // Pin controls; counter mode releases the shared pin
  always_ff @(posedge mclk)
  begin
    if (rst)
      pinCtl <= 3'h7;
    else
    begin
      pinCtl.sharedPinOeN   <= cs || pinDirection_reg[SHARED_BIT];
      pinCtl.pinWakeDisable <= option_reg.pinWakeDisable;
      pinCtl.pullupDisable  <= option_reg.pullupDisable;
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_timer_mode_step;
    (!cs && prescaler_assign && q4 && inhibit_reg == 2'h0 && !timerWr && !otherReset)
      |=> timer_reg == $past(timer_reg) + 8'h01;
  endproperty
  a_timer_mode_step: assert property (p_timer_mode_step)
    else $error("timer did not step on instruction cycle");

  property p_write_inhibit;
    (timerWr && !otherReset) ##1 (!timerWr)[*7]
      |-> timer_reg == $past(timer_reg, 6);
  endproperty
  a_write_inhibit: assert property (p_write_inhibit)
    else $error("timer moved inside write inhibit");

  property p_counter_step;
    (cs && incReq_reg && inhibit_reg == 2'h0 && !timerWr && !otherReset)
      |=> timer_reg == $past(timer_reg) + 8'h01;
  endproperty
  a_counter_step: assert property (p_counter_step)
    else $error("counter mode missed a step");

  property p_edge_to_presc;
    (cs && !prescaler_assign && extEdge && !timerWr && !otherReset)
      |=> presc_reg == $past(presc_reg) + 8'h01;
  endproperty
  a_edge_to_presc: assert property (p_edge_to_presc)
    else $error("selected edge did not reach prescaler");

  property p_exclusive;
    !prescaler_assign |=> !watchdogPostTick;
  endproperty
  a_exclusive: assert property (p_exclusive)
    else $error("watchdog ticked while prescaler serves timer");

  property p_write_clears;
    (timerWr && !prescaler_assign) |=> presc_reg == PRESC_RESET;
  endproperty
  a_write_clears: assert property (p_write_clears)
    else $error("timer write left prescaler");

  property p_wdt_clears;
    (cpuReq.watchdogClearOp && prescaler_assign) |=> presc_reg == PRESC_RESET;
  endproperty
  a_wdt_clears: assert property (p_wdt_clears)
    else $error("watchdog clear left prescaler");

  property p_reset_clears;
    otherReset |=> presc_reg == PRESC_RESET;
  endproperty
  a_reset_clears: assert property (p_reset_clears)
    else $error("reset left prescaler");

  property p_pin_forced;
    cs |=> pinCtl.sharedPinOeN;
  endproperty
  a_pin_forced: assert property (p_pin_forced)
    else $error("shared pin driven in counter mode");

  property p_timer_kept;
    (otherReset && !timerWr) |=> timer_reg == $past(timer_reg);
  endproperty
  a_timer_kept: assert property (p_timer_kept)
    else $error("timer changed on warm reset");

  property p_option_ones;
    otherReset |=> option_reg == OPTION_RESET;
  endproperty
  a_option_ones: assert property (p_option_ones)
    else $error("option not all ones after reset");

  property p_wrap;
    (timer_reg == 8'hff && timerInc && inhibit_reg == 2'h0 && !timerWr &&
     !otherReset) |=> timer_reg == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("timer did not wrap to zero");

  property p_cov_wrap;
    timer_reg == 8'hff ##1 timer_reg == 8'h00;
  endproperty
  c_cov_wrap: cover property (p_cov_wrap);

  property p_cov_ext;
    cs && !prescaler_assign && incReq_reg;
  endproperty
  c_cov_ext: cover property (p_cov_ext);

  property p_cov_wdt;
    watchdogPostTick;
  endproperty
  c_cov_wdt: cover property (p_cov_wdt);

  property p_cov_inhibit;
    timerWr ##1 (inhibit_reg == INHIBIT_CYC);
  endproperty
  c_cov_inhibit: cover property (p_cov_inhibit);

  property p_cov_wdt_clear;
    cpuReq.watchdogClearOp && prescaler_assign;
  endproperty
  c_cov_wdt_clear: cover property (p_cov_wdt_clear);

endmodule

`default_nettype wire

// file: inc/ebtp_pkg.sv
// Constants and carrier types for the 8-bit timer with shared prescaler.
// Assumes one 20 MHz clock; one clock period stands for one oscillator
// period, and four of them make one instruction cycle.
package ebtp_pkg;

  localparam int        MCLK_HZ        = 20_000_000;
  localparam int        TOSC_NS        = 1_000_000_000 / MCLK_HZ;
  localparam int        EDGE_DLY_MIN   = 3;
  localparam int        EDGE_DLY_MAX   = 7;

  localparam logic [4:0] TIMER_ADDR    = 5'h01;
  localparam logic [7:0] OPTION_RESET  = 8'hff;
  localparam logic [5:0] DIR_RESET     = 6'h3f;
  localparam logic [7:0] PRESC_RESET   = 8'h00;
  localparam logic [7:0] TIMER_PORRST  = 8'h00;
  localparam logic [7:0] READ_ZERO     = 8'h00;
  localparam logic [1:0] INHIBIT_CYC   = 2'h2;
  localparam int         SHARED_BIT    = 2;

  localparam logic [1:0] PHASE_Q1      = 2'h0;
  localparam logic [1:0] PHASE_Q2      = 2'h1;
  localparam logic [1:0] PHASE_Q3      = 2'h2;
  localparam logic [1:0] PHASE_Q4      = 2'h3;

  // Option register layout, most significant bit first
  typedef struct packed {
    logic       pinWakeDisable;
    logic       pullupDisable;
    logic       clockSourceSelect;
    logic       sourceEdgeSelect;
    logic       prescalerAssign;
    logic [2:0] prescaleRatioSel;
  } ebtp_option_t;

  // One CPU access, presented during the Q4 cycle of an instruction
  typedef struct packed {
    logic       fileWe;
    logic [4:0] fileAddr;
    logic [7:0] fileWdata;
    logic       optionWe;
    logic       dirWe;
    logic       watchdogClearOp;
  } ebtp_cpu_req_t;

  // Pin-side controls for the shared count pin and the port
  typedef struct packed {
    logic sharedPinOeN;
    logic pinWakeDisable;
    logic pullupDisable;
  } ebtp_pin_ctl_t;

endpackage

// file: tb/ebtp_count_src.sv
// Model of the external count source on the shared count pin.
// Assumes one caller at a time; the pin idles at its last level.
`timescale 1ns/1ps
`default_nettype none

module ebtp_count_src
#(
  parameter int HOLD_NS = 150
)
(
  output var logic extCountInput
);
  initial extCountInput = 1'b0;

  // Each level held past two periods plus margin
  task automatic toggle(input int n);
    repeat (n)
    begin
      #(HOLD_NS) extCountInput = ~extCountInput;
    end
    #(HOLD_NS);
  endtask
endmodule

`default_nettype wire

// file: tb/tb_eight_bit_timer_prescaler.sv
// Self-checking bench for the timer with shared prescaler.
// Assumes the bench plays the CPU, one access per Q4 cycle.
`timescale 1ns/1ps
`default_nettype none

module tb_eight_bit_timer_prescaler;
  import ebtp_pkg::*;
  logic          mclk;
  logic          rst;
  logic          otherReset;
  ebtp_cpu_req_t cpuReq;
  logic [7:0]    fileRdata;
  logic          extCountInput;
  logic          watchdogTick;
  logic          watchdogPostTick;
  logic          instrTick;
  ebtp_pin_ctl_t pinCtl;
  int            error_cnt;
  int            checked;
  int            postCnt;
  localparam ebtp_cpu_req_t IDLE =
    '{1'b0, TIMER_ADDR, 8'h00, 1'b0, 1'b0, 1'b0};

  ebtp_timer dut
  (
    .mclk             (mclk),
    .rst              (rst),
    .otherReset       (otherReset),
    .cpuReq           (cpuReq),
    .fileRdata        (fileRdata),
    .extCountInput    (extCountInput),
    .watchdogTick     (watchdogTick),
    .watchdogPostTick (watchdogPostTick),
    .instrTick        (instrTick),
    .pinCtl           (pinCtl)
  );

  ebtp_count_src src
  (
    .extCountInput (extCountInput)
  );

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  always @(posedge mclk)
    if (watchdogPostTick === 1'b1)
      postCnt++;

  task automatic nx(input int n);
    repeat (n)
    begin
      @(posedge mclk);
      #1;
    end
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input logic [7:0] got, input logic [7:0] lo,
                         input logic [7:0] hi);
    checked++;
    if ((^got) === 1'bx || got < lo || got > hi)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  function automatic ebtp_cpu_req_t mk(input logic [3:0] k,
                                       input logic [4:0] a,
                                       input logic [7:0] d);
    mk = '{k[3], a, d, k[2], k[1], k[0]};
  endfunction

  // Waits for a Q4 cycle, holds the access for that one cycle
  task automatic op(input ebtp_cpu_req_t r);
    do nx(1); while (instrTick !== 1'b1);
    nx(3);
    cpuReq = r;
    nx(1);
    cpuReq = IDLE;
  endtask

  task automatic wt(input logic [7:0] d);
    op(mk(4'h8, TIMER_ADDR, d));
  endtask

  task automatic wo(input logic [7:0] d);
    op(mk(4'h4, TIMER_ADDR, d));
  endtask

  task automatic cw;
    op(mk(4'h1, TIMER_ADDR, 8'h00));
  endtask

  task automatic wd(input int n);
    repeat (n)
    begin
      watchdogTick = 1'b1;
      nx(1);
      watchdogTick = 1'b0;
      nx(3);
    end
  endtask

  task automatic t_reset;
    nx(2);
    chk({5'h00, pinCtl}, 8'h07);
    chk(fileRdata, TIMER_PORRST);
  endtask

  task automatic t_timer;
    wo(8'hc8);
    wt(8'hfe);
    nx(2);
    for (int k = 0; k < 5; k++)
    begin
      if (k > 0)
        nx(4);
      chk(fileRdata, (k < 3) ? 8'hfe : 8'(8'hfc + k));
    end
  endtask

  task automatic t_presc;
    cw();
    for (int r = 0; r < 8; r++)
    begin
      wo(8'hc0 | 8'(r));
      wt(8'h00);
      nx(26 << r);
      chk_rng(fileRdata, (r < 2) ? 8'h02 : 8'h03, 8'h03);
    end
  endtask

  task automatic t_counter;
    op(mk(4'h2, TIMER_ADDR, 8'h00));
    nx(3);
    chk({7'h00, pinCtl.sharedPinOeN}, 8'h00);
    wt(8'h00);
    for (int e = 0; e < 3; e++)
    begin
      cw();
      wo((e == 2) ? 8'he0 : (e ? 8'hf8 : 8'he8));
      wt(8'h00);
      nx(12);
      chk({7'h00, pinCtl.sharedPinOeN}, 8'h01);
      src.toggle(3);
      nx(10);
      chk(fileRdata, (e == 2) ? 8'h01 : 8'h02);
    end
  endtask

  task automatic t_wdog;
    wo(8'hfa);
    cw();
    wd(2);
    cw();
    postCnt = 0;
    wd(6);
    nx(2);
    chk(8'(postCnt), 8'h01);
  endtask

  task automatic t_regs;
    wo(8'h38);
    op(mk(4'h8, 5'h07, 8'haa));
    nx(2);
    chk(fileRdata, 8'h01);
    cpuReq.fileAddr = 5'h07;
    nx(2);
    chk(fileRdata, READ_ZERO);
    cpuReq = IDLE;
    otherReset = 1'b1;
    nx(1);
    otherReset = 1'b0;
    nx(3);
    chk(fileRdata, 8'h01);
    chk({5'h00, pinCtl}, 8'h07);
  endtask

  task automatic end_of_test;
    if (error_cnt == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    error_cnt = 0;
    checked = 0;
    postCnt = 0;
    rst = 1'b1;
    otherReset = 1'b0;
    cpuReq = IDLE;
    watchdogTick = 1'b0;
    nx(8);
    rst = 1'b0;
    t_reset();
    t_timer();
    t_presc();
    t_counter();
    t_wdog();
    t_regs();
    end_of_test();
  end

  initial
  begin
    repeat (40000) @(posedge mclk);
    error_cnt++;
    end_of_test();
  end
endmodule

`default_nettype wire
